// ==== core/rh_sensor_defines.vh ====
/*
  Constants of the humidity/temperature sensor bus slave: bus address,
  command codes and checksum parameters.
  Assumes it is included by bare name from the design files under core/.
*/
`ifndef RH_SENSOR_DEFINES_VH
`define RH_SENSOR_DEFINES_VH

// fixed 7-bit bus address
`define DEV_ADDR        7'h54

// command codes
`define CMD_HOLD_T      8'he3
`define CMD_NOHOLD_T    8'hf3
`define CMD_HOLD_HT     8'he5
`define CMD_NOHOLD_HT   8'hf5
`define CMD_REG_RD      8'ha7
`define CMD_REG_WR      8'ha6
`define CMD_ID_RD       8'hd7
`define CMD_STOP_PER    8'h30

// checksum: polynomial and initial value
`define CRC_POLY        8'h1d
`define CRC_INIT        8'hff

// index of the last byte of each read sequence (checksum byte)
`define LAST_IDX_HT     3'h4
`define LAST_IDX_T      3'h2

// byte sent once a sequence is exhausted
`define FILL_BYTE       8'hff

`endif

// ==== core/result_buffer.v ====
/*
  Small valid/ready buffer holding conversion results on their way from
  the conversion core to the bus slave.
  Assumes one clock, active-low asynchronous reset, DEPTH = 2**AW.
*/
`timescale 1ns/1ps
`default_nettype none

module result_buffer #(
  parameter WIDTH = 28,
  parameter AW    = 1,
  parameter DEPTH = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;
  reg [AW:0]      count_d;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_q];

  // next fill level
  always @*
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  // pointers, level and a registered ready so the source sees a flop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q  <= count_d;
      in_ready <= (count_d != DEPTH[AW:0]);
    end
  end

  // storage needs no reset; valid flags guard it
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

endmodule

`default_nettype wire

// ==== core/rh_sensor_i2c_slave.v ====
/*
  Two-wire bus slave command port of a humidity/temperature sensor:
  address match, command decode, hold/no-hold measurement handshake,
  result transmission with checksum, register byte pass-through.
  Assumes scl/sda pins arrive asynchronously and are oversampled by clk
  (25 MHz); the conversion core and register store run on clk.
*/
// Operation
// - slave only, works at 100 kHz and 400 kHz bus rates
// - answer only bus address 0x54, others are not ours
// - sample sda on scl rise, sender holds sda while scl high
// - direction bit 1 means read from sensor, 0 means write
// - each byte is eight bits plus ack bit, low is ack
// - 0xe5 hold humidity+temperature, 0xf5 no-hold humidity+temperature
// - 0xe3/0xf3 temperature only, two bytes plus checksum byte
// - humidity+temperature returns humidity then temperature, four bytes
// - 0xa7 register read, 0xa6 register write, 0xd7 id read
// - 0x30 halts periodic measurement
// - hold command: keep scl low until the result is ready
// - no-hold command: scl left free during conversion
// - no-hold read: ack and send if ready, else nack
// - readings go out most significant bit first
// - checksum crc8 poly 0x1d init 0xff over four bytes
// - temperature-only checksum treats humidity bytes as zero
`timescale 1ns/1ps
`default_nettype none
`include "rh_sensor_defines.vh"

module rh_sensor_i2c_slave #(
  parameter RES_W = 14
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // bus pins, open drain: drive low while oe is high
  input  wire             scl_i,
  output reg              scl_o,
  output reg              scl_oe,
  input  wire             sda_i,
  output reg              sda_o,
  output reg              sda_oe,
  // conversion core
  output reg              meas_start,
  output reg              meas_humid,
  input  wire             res_valid,
  output wire             res_ready,
  input  wire [RES_W-1:0] res_hum,
  input  wire [RES_W-1:0] res_temp,
  // command and register side
  output reg              cmd_valid,
  output reg  [7:0]       cmd_code,
  output reg              wr_valid,
  output reg  [7:0]       wr_byte,
  output reg              rd_take,
  output reg              id_sel,
  input  wire [7:0]       rd_byte,
  output reg              stop_periodic
);

  ////////////////////////////////////////////////////////////////////////
  // states
  localparam [2:0] S_IDLE    = 3'h0;
  localparam [2:0] S_ADDR    = 3'h1;
  localparam [2:0] S_RX      = 3'h2;
  localparam [2:0] S_ACK     = 3'h3;
  localparam [2:0] S_TX      = 3'h4;
  localparam [2:0] S_MACK    = 3'h5;
  localparam [2:0] S_STRETCH = 3'h6;
  localparam [2:0] S_IGN     = 3'h7;
  localparam       PAD       = 16 - RES_W;

  reg  [2:0]       scl_sync_q;
  reg  [2:0]       sda_sync_q;
  reg  [2:0]       state_q;
  reg  [3:0]       bit_cnt_q;
  reg  [7:0]       shift_q;
  reg  [2:0]       idx_q;
  reg              first_q;
  reg              read_q;
  reg              hold_q;
  reg              busy_q;
  reg              have_q;
  reg              reg_src_q;
  reg  [RES_W-1:0] hum_q;
  reg  [RES_W-1:0] temp_q;
  reg  [7:0]       crc_q;
  reg  [7:0]       tx_byte;
  wire             scl_rise;
  wire             scl_fall;
  wire             bus_start;
  wire             bus_stop;
  wire             buf_valid;
  wire             buf_pop;
  wire [2*RES_W-1:0] buf_data;
  wire [15:0]      hum16;
  wire [15:0]      temp16;
  wire [2:0]       last_idx;

  ////////////////////////////////////////////////////////////////////////
  // two-flop sync, third stage only for edge finding
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  // oversampling at 25 MHz resolves 400 kHz edges easily
  assign scl_rise  = scl_sync_q[1] & ~scl_sync_q[2];
  assign scl_fall  = ~scl_sync_q[1] & scl_sync_q[2];
  // sda moving while scl high is a frame mark, never data
  assign bus_start = scl_sync_q[1] & scl_sync_q[2] &
                     ~sda_sync_q[1] & sda_sync_q[2];
  assign bus_stop  = scl_sync_q[1] & scl_sync_q[2] &
                     sda_sync_q[1] & ~sda_sync_q[2];

  ////////////////////////////////////////////////////////////////////////
  // result buffer: a stalled bus side loses no conversion
  result_buffer #(
    .WIDTH (2*RES_W),
    .AW    (1),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   ({res_hum, res_temp}),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // take a new result only once the previous one is delivered
  assign buf_pop = buf_valid & ~have_q;

  ////////////////////////////////////////////////////////////////////////
  // checksum over 32 bits, msb first
  function [7:0] crc8;
    input [31:0] d;
    reg   [7:0]  c;
    integer      i;
    begin
      c = `CRC_INIT;
      for (i = 31; i >= 0; i = i - 1)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
      crc8 = c;
    end
  endfunction

  assign hum16    = {{PAD{1'b0}}, hum_q};
  assign temp16   = {{PAD{1'b0}}, temp_q};
  assign last_idx = meas_humid ? `LAST_IDX_HT : `LAST_IDX_T;

  // byte to send next; humidity then temperature, high byte first
  always @*
  begin
    tx_byte = `FILL_BYTE;
    if (reg_src_q)
      tx_byte = rd_byte;
    else if (meas_humid)
      case (idx_q)
        3'h0:    tx_byte = hum16[15:8];
        3'h1:    tx_byte = hum16[7:0];
        3'h2:    tx_byte = temp16[15:8];
        3'h3:    tx_byte = temp16[7:0];
        3'h4:    tx_byte = crc_q;
        default: tx_byte = `FILL_BYTE;
      endcase
    else
      case (idx_q)
        3'h0:    tx_byte = temp16[15:8];
        3'h1:    tx_byte = temp16[7:0];
        3'h2:    tx_byte = crc_q;
        default: tx_byte = `FILL_BYTE;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // protocol engine; the device never masters the bus
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q       <= S_IDLE;
      bit_cnt_q     <= 4'h0;
      shift_q       <= 8'h00;
      idx_q         <= 3'h0;
      first_q       <= 1'b0;
      read_q        <= 1'b0;
      hold_q        <= 1'b0;
      busy_q        <= 1'b0;
      have_q        <= 1'b0;
      reg_src_q     <= 1'b0;
      hum_q         <= {RES_W{1'b0}};
      temp_q        <= {RES_W{1'b0}};
      crc_q         <= 8'h00;
      scl_o         <= 1'b0;
      scl_oe        <= 1'b0;
      sda_o         <= 1'b0;
      sda_oe        <= 1'b0;
      meas_start    <= 1'b0;
      meas_humid    <= 1'b0;
      cmd_valid     <= 1'b0;
      cmd_code      <= 8'h00;
      wr_valid      <= 1'b0;
      wr_byte       <= 8'h00;
      rd_take       <= 1'b0;
      id_sel        <= 1'b0;
      stop_periodic <= 1'b0;
    end
    else
    begin
      meas_start    <= 1'b0;
      cmd_valid     <= 1'b0;
      wr_valid      <= 1'b0;
      rd_take       <= 1'b0;
      stop_periodic <= 1'b0;

      // latch a finished conversion and its checksum
      if (buf_pop)
      begin
        hum_q  <= buf_data[2*RES_W-1:RES_W];
        temp_q <= buf_data[RES_W-1:0];
        // humidity bytes count as zero for temperature only
        crc_q  <= crc8({meas_humid ? {{PAD{1'b0}}, buf_data[2*RES_W-1:RES_W]}
                                   : 16'h0000,
                        {PAD{1'b0}}, buf_data[RES_W-1:0]});
        have_q <= 1'b1;
        busy_q <= 1'b0;
      end

      if (bus_start)
      begin
        state_q   <= S_ADDR;
        bit_cnt_q <= 4'h0;
        idx_q     <= 3'h0;
        first_q   <= 1'b1;
        sda_oe    <= 1'b0;
        scl_oe    <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_q <= S_IDLE;
        sda_oe  <= 1'b0;
        scl_oe  <= 1'b0;
      end
      else
        case (state_q)
          S_ADDR, S_RX:
          begin
            // eight data bits, then the ack slot
            if (scl_rise && bit_cnt_q != 4'h8)
            begin
              shift_q   <= {shift_q[6:0], sda_sync_q[1]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8 && state_q == S_ADDR)
            begin
              if (shift_q[7:1] != `DEV_ADDR)
                state_q <= S_IGN;
              else if (!shift_q[0])
              begin
                read_q  <= 1'b0;
                sda_oe  <= 1'b1;
                state_q <= S_ACK;
              end
              else if (have_q || reg_src_q)
              begin
                read_q  <= 1'b1;
                sda_oe  <= 1'b1;
                state_q <= S_ACK;
              end
              else if (busy_q && hold_q)
              begin
                scl_oe  <= 1'b1;
                state_q <= S_STRETCH;
              end
              else
                state_q <= S_IGN;                  // not ready: nack
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              sda_oe  <= 1'b1;
              state_q <= S_ACK;
              first_q <= 1'b0;
              if (first_q)
              begin
                cmd_valid <= 1'b1;
                cmd_code  <= shift_q;
                case (shift_q)
                  `CMD_HOLD_T, `CMD_NOHOLD_T, `CMD_HOLD_HT, `CMD_NOHOLD_HT:
                  begin
                    // hold keeps scl low later; no-hold leaves it free
                    meas_start <= 1'b1;
                    meas_humid <= shift_q[2];
                    hold_q     <= ~shift_q[4];
                    busy_q     <= 1'b1;
                    have_q     <= 1'b0;
                    reg_src_q  <= 1'b0;
                  end
                  `CMD_REG_RD, `CMD_ID_RD:
                  begin
                    reg_src_q <= 1'b1;
                    id_sel    <= shift_q[4];
                  end
                  `CMD_REG_WR:
                    reg_src_q <= 1'b0;
                  `CMD_STOP_PER:
                    stop_periodic <= 1'b1;
                  default:
                    reg_src_q <= reg_src_q;
                endcase
              end
              else
              begin
                // bytes after the command go to the register store
                wr_valid <= 1'b1;
                wr_byte  <= shift_q;
              end
            end
          end
          S_STRETCH:
          begin
            // set ack on sda first, release scl a cycle later
            if (have_q && !sda_oe)
            begin
              sda_oe <= 1'b1;
              read_q <= 1'b1;
            end
            else if (sda_oe)
            begin
              scl_oe  <= 1'b0;
              state_q <= S_ACK;
            end
          end
          S_ACK:
          begin
            if (scl_fall && read_q)
            begin
              shift_q   <= tx_byte;
              sda_oe    <= ~tx_byte[7];            // msb first
              bit_cnt_q <= 4'h0;
              idx_q     <= idx_q + 3'h1;
              state_q   <= S_TX;
              if (reg_src_q)
                rd_take <= 1'b1;
              else if (idx_q == last_idx)
                have_q  <= 1'b0;                   // checksum byte loaded
            end
            else if (scl_fall)
            begin
              sda_oe    <= 1'b0;
              bit_cnt_q <= 4'h0;
              state_q   <= S_RX;
            end
          end
          S_TX:
          begin
            if (scl_fall && bit_cnt_q == 4'h7)
            begin
              sda_oe  <= 1'b0;                     // free sda for ack
              state_q <= S_MACK;
            end
            else if (scl_fall)
            begin
              shift_q   <= {shift_q[6:0], 1'b0};
              sda_oe    <= ~shift_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          S_MACK:
          begin
            // master ack continues, nack ends our part
            if (scl_rise)
              state_q <= sda_sync_q[1] ? S_IGN : S_ACK;
          end
          S_IGN:
            sda_oe <= 1'b0;                        // wait for start
          default:
            state_q <= S_IDLE;
        endcase
    end
  end

endmodule

`default_nettype wire

// ==== verification/rh_sensor_checker.sv ====
/*
  Concurrent checks on the pins and pulses of the sensor bus slave.
  Assumes binding to rh_sensor_i2c_slave, with scl_i and sda_i carrying
  the resolved open-drain wire levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rh_sensor_defines.vh"

module rh_sensor_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // bus pins
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  // command side
  input wire logic       meas_start,
  input wire logic       meas_humid,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       wr_valid,
  input wire logic       stop_periodic
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // pin behaviour: open drain, sda moves only while scl is low
  a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("bus output value is not low");
  a_sda_on_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda pull changed while scl high");

  ////////////////////////////////////////////////////////////////////////
  // stretching: starts with scl low, ends with the ack already driven
  a_stretch_low: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch began while scl high");
  a_stretch_ack: assert property ($fell(scl_oe) |-> sda_oe)
    else $error("scl released before ack driven");
  a_release_next: assert property (scl_oe && sda_oe |=> !scl_oe)
    else $error("scl still held after ack");

  ////////////////////////////////////////////////////////////////////////
  // measurement and stop pulses agree with the code that caused them; start and write strobes last one cycle
  a_meas_pulse: assert property (meas_start |=> !meas_start)
    else $error("measurement start longer than one cycle");
  a_meas_code: assert property (meas_start |-> ##[0:3] (cmd_code inside
    {`CMD_HOLD_T, `CMD_NOHOLD_T, `CMD_HOLD_HT, `CMD_NOHOLD_HT}))
    else $error("measurement start without measurement code");
  a_meas_kind: assert property (meas_start |-> ##[0:3]
    (meas_humid == cmd_code[2]))
    else $error("measurement kind disagrees with code");
  a_stop_code: assert property (stop_periodic |-> ##[0:3]
    (cmd_code == `CMD_STOP_PER))
    else $error("periodic stop without its code");
  a_wr_pulse: assert property (wr_valid |=> !wr_valid)
    else $error("write byte strobe longer than one cycle");
endmodule

`default_nettype wire

// ==== verification/i2c_master_model.sv ====
/*
  Behavioural two-wire bus master used as the far side of the slave.
  Assumes the bench resolves both wires from every party's pull and
  calls the tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model #(
  parameter int HALF = 16
) (
  // pacing clock
  input  wire logic clk,
  // resolved wire levels
  input  wire logic scl,
  input  wire logic sda,
  // pulls, high while pulling low
  output var  logic scl_oe,
  output var  logic sda_oe
);
  int max_stretch;

  // idle: both wires released to the pull-up
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    max_stretch = 0;
  end

  task automatic pace(input int n);
    repeat (n) @(negedge clk);
  endtask

  // release scl; a slave may hold it, so the wait is bounded
  task automatic scl_up();
    int k;
    scl_oe = 1'b0;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (scl !== 1'b1 && k < 30000);
    if (k > max_stretch)
      max_stretch = k;
  endtask

  // sda only moves while scl low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    pace(HALF / 2);
    sda_oe = !b;
    pace(HALF / 2);
    scl_up();
    pace(HALF / 2 - 1);
    r = sda;
    pace(HALF / 2);
    scl_oe = 1'b1;
  endtask

  // start: sda falls while scl high
  task automatic start();
    sda_oe = 1'b0;
    pace(HALF / 2);
    scl_up();
    pace(HALF);
    sda_oe = 1'b1;
    pace(HALF);
    scl_oe = 1'b1;
  endtask

  // stop: sda rises while scl high, then bus free time
  task automatic stop();
    pace(HALF / 2);
    sda_oe = 1'b1;
    pace(HALF / 2);
    scl_up();
    pace(HALF);
    sda_oe = 1'b0;
    pace(2 * HALF);
  endtask

  // eight bits msb first, then the response bit
  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] rb, output logic ack);
    int i;
    for (i = 7; i >= 0; i--)
      bit_io(w[i], rb[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

`default_nettype wire

// ==== verification/rh_temp_sensor_i2c_command_port_tb.sv ====
/*
  Self-checking bench of the sensor bus slave: command table, foreign
  address, register bytes, hold and no-hold measurements, result buffer.
  Assumes the design files under core/ and the master model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rh_sensor_defines.vh"

module rh_temp_sensor_i2c_command_port_tb;
  localparam int LIMIT = 20000;
  typedef struct {logic [7:0] c; int ns; logic h; int nst; logic [1:0] id;} row_t;
  // code, starts, humid, stops, id select (2: not checked); 8'h5a undefined
  row_t rows [0:8] = '{'{`CMD_HOLD_T, 1, 1'b0, 0, 2'd2},
    '{`CMD_NOHOLD_T, 1, 1'b0, 0, 2'd2}, '{`CMD_HOLD_HT, 1, 1'b1, 0, 2'd2},
    '{`CMD_NOHOLD_HT, 1, 1'b1, 0, 2'd2}, '{`CMD_REG_RD, 0, 1'b0, 0, 2'd0},
    '{`CMD_REG_WR, 0, 1'b0, 0, 2'd2}, '{`CMD_ID_RD, 0, 1'b0, 0, 2'd1},
    '{`CMD_STOP_PER, 0, 1'b0, 1, 2'd2}, '{8'h5a, 0, 1'b0, 0, 2'd2}};
  logic        clk, rst_n, res_valid, a;
  logic [13:0] res_hum, res_temp;
  logic [7:0]  rd_byte, x;
  logic [7:0]  rb [0:7];
  int          errors, num_checks, cyc, n_cmd, n_meas, n_stop, n_wr, n_take;
  int          r, c0, s0, p0;
  wire         m_scl_oe, m_sda_oe, scl_o, scl_oe, sda_o, sda_oe, res_ready;
  wire         meas_start, meas_humid, cmd_valid, wr_valid, rd_take, id_sel;
  wire         stop_periodic;
  wire [7:0]   cmd_code, wr_byte;
  // wired-and bus with pull-ups
  wire         scl = !(m_scl_oe | scl_oe);
  wire         sda = !(m_sda_oe | sda_oe);

  rh_sensor_i2c_slave #(.RES_W(14)) dut_u (.clk(clk), .rst_n(rst_n),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .meas_start(meas_start), .meas_humid(meas_humid),
    .res_valid(res_valid), .res_ready(res_ready), .res_hum(res_hum),
    .res_temp(res_temp), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_take(rd_take),
    .id_sel(id_sel), .rd_byte(rd_byte), .stop_periodic(stop_periodic));
  // scl low and high four cycles each: 320 ns bit period
  i2c_master_model #(.HALF(4)) m_u (.clk(clk), .scl(scl), .sda(sda),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  ////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;

  // pulse counters and the hang limit
  always @(posedge clk)
  begin
    cyc++;
    n_cmd += (cmd_valid === 1'b1);
    n_meas += (meas_start === 1'b1);
    n_stop += (stop_periodic === 1'b1);
    n_wr += (wr_valid === 1'b1);
    n_take += (rd_take === 1'b1);
    if (cyc == LIMIT)
    begin
      errors++;
      $display("[FAIL] run time expected below %0d seen %0d", LIMIT, cyc);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_int(input string n, input int e, input int g);
    num_checks++;
    if (g != e)
    begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // crc8, msb first, over humidity then temperature words
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    int i;
    c = `CRC_INIT;
    for (i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
    return c;
  endfunction

  // write transaction: address, command, optional data byte
  task automatic wtr(input logic [7:0] c, input bit has_d, input logic [7:0] d);
    m_u.start();
    m_u.xfer({`DEV_ADDR, 1'b0}, 1'b1, x, a);
    chk_val("write address ack", 8'h00, {7'h0, a});
    m_u.xfer(c, 1'b1, x, a);
    chk_val("command ack", 8'h00, {7'h0, a});
    if (has_d)
      m_u.xfer(d, 1'b1, x, a);
    m_u.stop();
  endtask

  // read transaction of n bytes, master nacks the last one
  task automatic rd(input int n, input logic [7:0] exp_nack);
    int i;
    m_u.start();
    m_u.xfer({`DEV_ADDR, 1'b1}, 1'b1, x, a);
    chk_val("read address response", exp_nack, {7'h0, a});
    if (a === 1'b0)
      for (i = 0; i < n; i++)
        m_u.xfer(8'hff, (i == n - 1), rb[i], x);
    m_u.stop();
  endtask

  // core side: hold valid until the edge that finds ready high
  task automatic give(input logic [13:0] h, input logic [13:0] t);
    int k;
    res_hum = h;
    res_temp = t;
    res_valid = 1'b1;
    for (k = 0; k < 2000 && res_ready !== 1'b1; k++)
      @(negedge clk);
    @(negedge clk);
    res_valid = 1'b0;
    // let an edge see valid low before the next result
    @(negedge clk);
  endtask

  task automatic chk_meas(input logic [13:0] h, input logic [13:0] t, input bit hm);
    logic [15:0] h16;
    logic [7:0]  e [0:4];
    int          i;
    h16 = hm ? {2'b00, h} : 16'h0000;
    e = '{h16[15:8], h16[7:0], {2'b00, t[13:8]}, t[7:0], crc8({h16, 2'b00, t})};
    for (i = hm ? 0 : 2; i < 5; i++)
      chk_val("result byte", e[i], rb[i - (hm ? 0 : 2)]);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    res_valid = 1'b0;
    res_hum = 14'h0000;
    res_temp = 14'h0000;
    rd_byte = 8'h00;
    repeat (16) @(negedge clk);
    chk_val("pulls in reset", 8'h00, {6'h0, scl_oe, sda_oe});
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    done("reset");
    for (r = 0; r < 9; r++)
    begin
      c0 = n_cmd;
      s0 = n_meas;
      p0 = n_stop;
      wtr(rows[r].c, 1'b0, 8'h00);
      chk_int("command pulses", c0 + 1, n_cmd);
      chk_val("command code", rows[r].c, cmd_code);
      chk_int("start pulses", s0 + rows[r].ns, n_meas);
      if (rows[r].ns == 1)
        chk_val("measure kind", {7'h0, rows[r].h}, {7'h0, meas_humid});
      chk_int("stop pulses", p0 + rows[r].nst, n_stop);
      if (rows[r].id != 2'd2)
        chk_val("id select", {7'h0, rows[r].id[0]}, {7'h0, id_sel});
    end
    done("command table");
    c0 = n_cmd;
    m_u.start();
    m_u.xfer(8'h56, 1'b1, x, a);
    chk_val("foreign address", 8'h01, {7'h0, a});
    m_u.xfer(`CMD_HOLD_HT, 1'b1, x, a);
    chk_val("foreign byte", 8'h01, {7'h0, a});
    m_u.stop();
    chk_int("foreign commands", c0, n_cmd);
    done("foreign address");
    c0 = n_wr;
    wtr(`CMD_REG_WR, 1'b1, 8'h5a);
    chk_int("write pulses", c0 + 1, n_wr);
    chk_val("write byte", 8'h5a, wr_byte);
    rd_byte = 8'hc4;
    c0 = n_take;
    wtr(`CMD_REG_RD, 1'b0, 8'h00);
    rd(2, 8'h00);
    chk_val("register byte", 8'hc4, rb[1]);
    chk_int("register take", 1, int'(n_take > c0));
    done("register bytes");
    wtr(`CMD_HOLD_HT, 1'b0, 8'h00);
    m_u.max_stretch = 0;
    fork
      rd(5, 8'h00);
      begin
        repeat (800) @(negedge clk);
        give(14'h2a5c, 14'h1b3d);
      end
    join
    chk_int("clock held", 1, int'(m_u.max_stretch > 300));
    chk_meas(14'h2a5c, 14'h1b3d, 1'b1);
    done("hold measurement");
    wtr(`CMD_NOHOLD_T, 1'b0, 8'h00);
    m_u.max_stretch = 0;
    rd(3, 8'h01);
    chk_int("clock free", 1, int'(m_u.max_stretch < 4));
    give(14'h3fff, 14'h0581);
    give(14'h1111, 14'h2e07);
    give(14'h0000, 14'h0001);
    repeat (4) @(negedge clk);
    chk_val("buffer full", 8'h00, {7'h0, res_ready});
    repeat (400) @(negedge clk);
    rd(3, 8'h00);
    chk_meas(14'h3fff, 14'h0581, 1'b0);
    rd(3, 8'h00);
    chk_meas(14'h1111, 14'h2e07, 1'b0);
    chk_val("buffer drained", 8'h01, {7'h0, res_ready});
    done("no-hold measurement and buffer");
    summarize();
  end
endmodule

bind rh_sensor_i2c_slave rh_sensor_checker chk_u (.clk(clk), .rst_n(rst_n),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .meas_start(meas_start),
  .meas_humid(meas_humid), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .wr_valid(wr_valid), .stop_periodic(stop_periodic));

`default_nettype wire
